/* common/sps_pkg.sv */
/*
  Shared constants and carrier types for the page context stack.
  Assumes an 8-bit special function register bus with 8-bit addresses.
*/
package sps_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SPS_ADDR_ACTIVE_PAGE = 8'h84;
  localparam logic [7:0] SPS_ADDR_SECOND      = 8'h85;
  localparam logic [7:0] SPS_ADDR_THIRD       = 8'h86;
  localparam logic [7:0] SPS_ADDR_PAGING_CTRL = 8'h96;

  // page that holds the paging control register
  localparam logic [7:0] SPS_PAGING_CTRL_PAGE = 8'h0F;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         SPS_AUTO_EN_BIT      = 0;
  localparam logic [7:0] SPS_RST_ACTIVE_PAGE  = 8'h00;
  localparam logic [7:0] SPS_RST_SECOND       = 8'h00;
  localparam logic [7:0] SPS_RST_THIRD        = 8'h00;
  localparam logic [7:0] SPS_RST_PAGING_CTRL  = 8'h01;
  localparam logic [7:0] SPS_RD_UNMAPPED      = 8'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } sps_sfr_req_t;

  typedef struct packed {
    logic       rdValid;
    logic [7:0] rdData;
  } sps_sfr_rsp_t;

  typedef struct packed {
    logic       intEntry;
    logic       intReturn;
    logic [7:0] intPage;
  } sps_core_evt_t;

  // stack operation chosen in a cycle
  typedef enum logic [1:0] {
    SPS_OP_HOLD = 2'b00,
    SPS_OP_PUSH = 2'b01,
    SPS_OP_POP  = 2'b10
  } sps_op_t;

endpackage

/* hw/sps_page_stack.sv */
/*
  Three-entry page context stack with its special function registers:
  the live page selector on top, two software-visible entries below it,
  and the paging control register that switches the automatic stack shifts off.
  Assumes the core gives one-cycle pulses for interrupt entry and return,
  with the source page valid alongside the entry pulse, and that the
  register bus is synchronous to core_clk with one strobe per access.
  Read answers come one cycle after the strobe and return to zero after.
  A stack shift beats a same-cycle software write to any stack entry, and
  an entry pulse beats a return pulse that arrives in the same cycle.
*/

module sps_page_stack (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire sps_pkg::sps_sfr_req_t  sfrReq,
  output sps_pkg::sps_sfr_rsp_t       sfrRsp,
  input  wire sps_pkg::sps_core_evt_t coreEvt,
  output logic [7:0]                  activePageSelector,
  output logic                        autoPagingEnable
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------

  // true when addr names reg; page-bound registers also need their page
  function automatic logic addrHit(
    input logic [7:0] addr,
    input logic [7:0] target,
    input logic       allPages,
    input logic [7:0] curPage,
    input logic [7:0] regPage
  );
    addrHit = (addr == target) && (allPages || (curPage == regPage));
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] pageStackSecondEntry;
  logic [7:0] pageStackThirdEntry;
  logic [7:0] pagingControlRegister;
  logic [7:0] next_rdData;

  // ---------------------------------------------------------------
  // decode results
  // ---------------------------------------------------------------
  logic hitActive;
  logic hitSecond;
  logic hitThird;
  logic hitCtrl;
  logic wrActive;
  logic wrSecond;
  logic wrThird;
  logic wrCtrl;
  sps_pkg::sps_op_t stackOp;

  // top entry of the stack is the live selector
  assign hitActive = addrHit(sfrReq.addr,
                             sps_pkg::SPS_ADDR_ACTIVE_PAGE,
                             1'b1,
                             activePageSelector,
                             sps_pkg::SPS_PAGING_CTRL_PAGE);
  assign hitSecond = addrHit(sfrReq.addr,
                             sps_pkg::SPS_ADDR_SECOND,
                             1'b1,
                             activePageSelector,
                             sps_pkg::SPS_PAGING_CTRL_PAGE);
  assign hitThird  = addrHit(sfrReq.addr,
                             sps_pkg::SPS_ADDR_THIRD,
                             1'b1,
                             activePageSelector,
                             sps_pkg::SPS_PAGING_CTRL_PAGE);
  // control register is page-bound, so it decodes only on its own page
  assign hitCtrl   = addrHit(sfrReq.addr,
                             sps_pkg::SPS_ADDR_PAGING_CTRL,
                             1'b0,
                             activePageSelector,
                             sps_pkg::SPS_PAGING_CTRL_PAGE);

  // ---------------------------------------------------------------
  // write strobes
  // ---------------------------------------------------------------

  // unmapped addresses raise no strobe, so their writes are ignored

  assign wrActive = sfrReq.wrEn && hitActive;
  assign wrSecond = sfrReq.wrEn && hitSecond;
  assign wrThird  = sfrReq.wrEn && hitThird;
  assign wrCtrl   = sfrReq.wrEn && hitCtrl;

  // ---------------------------------------------------------------
  // stack operation select
  // ---------------------------------------------------------------

  // only core events shift the stack, and only while auto paging is on;
  // entry takes priority if both pulses coincide
  always_comb begin
    stackOp = sps_pkg::SPS_OP_HOLD;
    if (autoPagingEnable) begin
      if (coreEvt.intEntry) begin
        stackOp = sps_pkg::SPS_OP_PUSH;
      end else if (coreEvt.intReturn) begin
        stackOp = sps_pkg::SPS_OP_POP;
      end
    end
  end

  // ---------------------------------------------------------------
  // top entry
  // ---------------------------------------------------------------

  // a shift in the same cycle as a software write wins over the write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      activePageSelector <= sps_pkg::SPS_RST_ACTIVE_PAGE;
    end else begin
      case (stackOp)
        sps_pkg::SPS_OP_PUSH: begin
          activePageSelector <= coreEvt.intPage;
        end
        sps_pkg::SPS_OP_POP: begin
          activePageSelector <= pageStackSecondEntry;
        end
        sps_pkg::SPS_OP_HOLD: begin
          if (wrActive) begin
            activePageSelector <= sfrReq.wrData;
          end
        end
        default: begin
          activePageSelector <= activePageSelector;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // second entry
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pageStackSecondEntry <= sps_pkg::SPS_RST_SECOND;
    end else begin
      case (stackOp)
        sps_pkg::SPS_OP_PUSH: begin
          pageStackSecondEntry <= activePageSelector;
        end
        sps_pkg::SPS_OP_POP: begin
          pageStackSecondEntry <= pageStackThirdEntry;
        end
        sps_pkg::SPS_OP_HOLD: begin
          if (wrSecond) begin
            // value taken by the selector at the next return
            pageStackSecondEntry <= sfrReq.wrData;
          end
        end
        default: begin
          pageStackSecondEntry <= pageStackSecondEntry;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // third entry
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pageStackThirdEntry <= sps_pkg::SPS_RST_THIRD;
    end else begin
      case (stackOp)
        sps_pkg::SPS_OP_PUSH: begin
          // old bottom value is lost
          pageStackThirdEntry <= pageStackSecondEntry;
        end
        sps_pkg::SPS_OP_POP: begin
          // nothing defined to refill the bottom
          pageStackThirdEntry <= pageStackThirdEntry;
        end
        sps_pkg::SPS_OP_HOLD: begin
          if (wrThird) begin
            // moves into the second entry at the next return
            pageStackThirdEntry <= sfrReq.wrData;
          end
        end
        default: begin
          pageStackThirdEntry <= pageStackThirdEntry;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // paging control
  // ---------------------------------------------------------------

  // reserved bits 7..1 are not stored and read as zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pagingControlRegister <= sps_pkg::SPS_RST_PAGING_CTRL;
    end else if (wrCtrl) begin
      pagingControlRegister <= {7'h00,
                                sfrReq.wrData[sps_pkg::SPS_AUTO_EN_BIT]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      autoPagingEnable <= sps_pkg::SPS_RST_PAGING_CTRL[sps_pkg::SPS_AUTO_EN_BIT];
    end else if (wrCtrl) begin
      autoPagingEnable <= sfrReq.wrData[sps_pkg::SPS_AUTO_EN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // read data select
  // ---------------------------------------------------------------

  // idle and unmapped cycles answer zero
  always_comb begin
    next_rdData = sps_pkg::SPS_RD_UNMAPPED;
    if (sfrReq.rdEn) begin
      if (hitActive) begin
        next_rdData = activePageSelector;
      end else if (hitSecond) begin
        next_rdData = pageStackSecondEntry;
      end else if (hitThird) begin
        next_rdData = pageStackThirdEntry;
      end else if (hitCtrl) begin
        next_rdData = pagingControlRegister;
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  // registered read: data of the cycle before any same-cycle update
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sfrRsp.rdValid <= 1'b0;
      sfrRsp.rdData  <= sps_pkg::SPS_RD_UNMAPPED;
    end else begin
      sfrRsp.rdValid <= sfrReq.rdEn;
      sfrRsp.rdData  <= next_rdData;
    end
  end

endmodule // sps_page_stack

/* sim/sps_page_stack_monitor.sv */
/* Port checker of the page context stack.
   Assumes one clock domain and the bind at the foot of this file. */
module sps_page_stack_monitor (
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  input wire sps_pkg::sps_sfr_req_t  sfrReq,
  input wire sps_pkg::sps_sfr_rsp_t  sfrRsp,
  input wire sps_pkg::sps_core_evt_t coreEvt,
  input wire logic [7:0]             activePageSelector,
  input wire logic                   autoPagingEnable
);
  // ---------------------------------------------------------------
  // stack and register checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic wrTop = sfrReq.wrEn && sfrReq.addr == 8'h84;
  wire logic wrCtl = sfrReq.wrEn && sfrReq.addr == 8'h96;
  wire logic noEvt = !coreEvt.intEntry && !coreEvt.intReturn;
  sequence s_push; coreEvt.intEntry && autoPagingEnable; endsequence
  sequence s_pop; coreEvt.intReturn && !coreEvt.intEntry && autoPagingEnable; endsequence
  property p_push; s_push |=> activePageSelector == $past(coreEvt.intPage); endproperty
  a_push: assert property (p_push) else $error("push page");
  property p_pop; s_push ##1 s_pop |=> activePageSelector == $past(activePageSelector, 2);
  endproperty
  a_pop: assert property (p_pop) else $error("pop page");
  property p_hold; noEvt && !wrTop |=> $stable(activePageSelector); endproperty
  a_hold: assert property (p_hold) else $error("top moved");
  property p_off; !autoPagingEnable && !wrTop |=> $stable(activePageSelector); endproperty
  a_off: assert property (p_off) else $error("top moved while off");
  property p_wtop; wrTop && noEvt |=> activePageSelector == $past(sfrReq.wrData); endproperty
  a_wtop: assert property (p_wtop) else $error("top write");
  property p_wctl;
    wrCtl && activePageSelector == 8'h0F |=> autoPagingEnable == $past(sfrReq.wrData[0]);
  endproperty
  a_wctl: assert property (p_wctl) else $error("enable write");
  property p_ctl; !wrCtl |=> $stable(autoPagingEnable); endproperty
  a_ctl: assert property (p_ctl) else $error("enable moved");
  property p_rd; sfrReq.rdEn |=> sfrRsp.rdValid; endproperty
  a_rd: assert property (p_rd) else $error("read answer");
  property p_idle; !sfrReq.rdEn |=> !sfrRsp.rdValid && sfrRsp.rdData == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle answer");
endmodule // sps_page_stack_monitor

bind sps_page_stack sps_page_stack_monitor sps_page_stack_monitor_i (.core_clk(core_clk),
  .rst_n(rst_n), .sfrReq(sfrReq), .sfrRsp(sfrRsp), .coreEvt(coreEvt),
  .activePageSelector(activePageSelector), .autoPagingEnable(autoPagingEnable));

/* sim/sps_core_model.sv */
/* Core side source of interrupt entry and return pulses.
   Assumes callers stand just after a rising edge. */
module sps_core_model (
  input wire logic               core_clk,
  output sps_pkg::sps_core_evt_t coreEvt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastIn = 1'b0;
  logic lastOut = 1'b0;
  initial coreEvt = '0;
  // page is valid only with the pulse, so it is scrambled afterwards
  task automatic enter(input logic [7:0] page);
    if (lastIn) begin
      @(posedge core_clk);
      #1;
    end
    coreEvt.intEntry = 1'b1;
    coreEvt.intPage = page;
    @(posedge core_clk);
    #1;
    coreEvt.intEntry = 1'b0;
    coreEvt.intPage = ~page;
    lastIn = 1'b1;
    lastOut = 1'b0;
  endtask
  // entry and return in one cycle: the stack must see only the push
  task automatic both(input logic [7:0] page);
    if (lastIn || lastOut) begin
      @(posedge core_clk);
      #1;
    end
    coreEvt.intEntry = 1'b1;
    coreEvt.intReturn = 1'b1;
    coreEvt.intPage = page;
    @(posedge core_clk);
    #1;
    coreEvt.intEntry = 1'b0;
    coreEvt.intReturn = 1'b0;
    coreEvt.intPage = ~page;
    lastIn = 1'b1;
    lastOut = 1'b1;
  endtask
  task automatic leave();
    if (lastOut) begin
      @(posedge core_clk);
      #1;
    end
    coreEvt.intReturn = 1'b1;
    @(posedge core_clk);
    #1;
    coreEvt.intReturn = 1'b0;
    lastOut = 1'b1;
    lastIn = 1'b0;
  endtask
endmodule // sps_core_model

/* sim/tb_top.sv */
/* Self-checking bench of the page context stack.
   Assumes the package, core model and checker compile first. */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   core_clk = 1'b0;
  logic                   rst_n = 1'b0;
  sps_pkg::sps_sfr_req_t  sfrReq = '0;
  sps_pkg::sps_sfr_rsp_t  sfrRsp;
  sps_pkg::sps_core_evt_t coreEvt;
  logic [7:0]             activePageSelector;
  logic                   autoPagingEnable;
  logic [7:0]             expTop = 8'h00, expSec = 8'h00, expThr = 8'h00;
  logic                   expEn = 1'b1;
  logic [7:0]             addrs [5] = '{8'h84, 8'h85, 8'h86, 8'h96, 8'h87};
  int                     fails = 0, checks_done = 0, cycles = 0;
  always #5 core_clk = ~core_clk;
  sps_page_stack sps_page_stack_i (.core_clk(core_clk), .rst_n(rst_n), .sfrReq(sfrReq),
    .sfrRsp(sfrRsp), .coreEvt(coreEvt), .activePageSelector(activePageSelector),
    .autoPagingEnable(autoPagingEnable));
  sps_core_model sps_core_model_i (.core_clk(core_clk), .coreEvt(coreEvt));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] rd_exp(input logic [7:0] a);
    case (a)
      8'h84: return expTop;
      8'h85: return expSec;
      8'h86: return expThr;
      8'h96: return (expTop == 8'h0F) ? {7'h00, expEn} : 8'h00;
      default: return 8'h00;
    endcase
  endfunction
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    sfrReq = {w, r, a, d};
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    if (a == 8'h96 && expTop == 8'h0F) expEn = d[0];
    if (a == 8'h84) expTop = d;
    if (a == 8'h85) expSec = d;
    if (a == 8'h86) expThr = d;
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = rd_exp(a);
    bus(1'b0, 1'b1, a, ~a);
    chk("rdValid", 8'h01, {7'h00, sfrRsp.rdValid});
    chk("rdData", e, sfrRsp.rdData);
  endtask
  // the bus goes idle so no stale write rides along with a shift
  task automatic ent(input logic [7:0] p);
    sfrReq = '0;
    sps_core_model_i.enter(p);
    if (expEn) {expThr, expSec, expTop} = {expSec, expTop, p};
  endtask
  // a stack write that meets a push is dropped, the push wins
  task automatic entw(input logic [7:0] p, a, d);
    sfrReq = {1'b1, 1'b0, a, d};
    sps_core_model_i.enter(p);
    sfrReq = '0;
    if (expEn) {expThr, expSec, expTop} = {expSec, expTop, p};
  endtask
  task automatic entret(input logic [7:0] p);
    sfrReq = '0;
    sps_core_model_i.both(p);
    if (expEn) {expThr, expSec, expTop} = {expSec, expTop, p};
  endtask
  task automatic ret();
    sfrReq = '0;
    sps_core_model_i.leave();
    if (expEn) {expTop, expSec} = {expSec, expThr};
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 3000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    logic [7:0] a, d;
    void'($urandom(32'h59EE040F));
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    foreach (addrs[i]) rd(addrs[i]);
    wr(8'h84, 8'h0F);
    rd(8'h96);
    wr(8'h86, 8'hAA);
    wr(8'h85, 8'h55);
    ret();
    chk("activePageSelector", 8'h55, activePageSelector);
    rd(8'h85);
    rd(8'h86);
    ent(8'h02);
    ent(8'h00);
    rd(8'h86);
    ret();
    ret();
    chk("activePageSelector", 8'h55, activePageSelector);
    entw(8'h44, 8'h85, 8'h77);
    rd(8'h85);
    entret(8'h66);
    chk("activePageSelector", 8'h66, activePageSelector);
    rd(8'h85);
    rd(8'h86);
    wr(8'h84, 8'h01);
    wr(8'h96, 8'h00);
    chk("autoPagingEnable", 8'h01, {7'h00, autoPagingEnable});
    wr(8'h84, 8'h0F);
    wr(8'h96, 8'h00);
    chk("autoPagingEnable", 8'h00, {7'h00, autoPagingEnable});
    ent(8'h33);
    ret();
    chk("activePageSelector", 8'h0F, activePageSelector);
    wr(8'h96, 8'h01);
    repeat (120) begin
      a = addrs[$urandom_range(0, 4)];
      d = 8'($urandom);
      case ($urandom_range(0, 3))
        0: if (a != 8'h96) wr(a, d);
        1: rd(a);
        2: ent(d);
        default: ret();
      endcase
      chk("activePageSelector", expTop, activePageSelector);
    end
    end_sim();
  end
endmodule // tb_top
